// *** inc/ubt_pkg.sv ***
package ubt_pkg;
   // data width of each port
   localparam int unsigned DATA_W     = 18;
   // entries in each direction's buffer
   localparam int unsigned BUF_DEPTH  = 2;
   // direction indices
   localparam int unsigned DIR_AB     = 0;
   localparam int unsigned DIR_BA     = 1;
   localparam int unsigned NUM_DIR    = 2;
   // reset values
   localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
   localparam logic              OE_RST   = 1'b0;
   localparam logic              PIN_RST  = 1'b0;
   // output path latency: push, head valid, output register
   localparam int unsigned PATH_LAT   = 2;
endpackage

// *** hdl/ubt_fifo.sv ***
`timescale 1ns/1ps
// small first-in first-out store, valid/ready on both sides
module ubt_fifo #(
   parameter int unsigned WIDTH = ubt_pkg::DATA_W,
   parameter int unsigned DEPTH = ubt_pkg::BUF_DEPTH
) (
   // clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             srst_i,
   // filling side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // draining side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_ptr_q;
   logic [PW-1:0]    rd_ptr_q;
   logic [PW:0]      cnt_q;
   logic             push;
   logic             pop;

   // honest full and empty flags straight from the count
   assign in_ready_o  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_ptr_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // storage array, written only on an accepted push
   always_ff @(posedge ref_clk_i)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
      end
   end

   // occupancy count
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         cnt_q <= '0;
      end
      else if (push && !pop)
      begin
         cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

// *** hdl/ubt_transceiver.sv ***
`timescale 1ns/1ps
module ubt_transceiver #(
   parameter int unsigned WIDTH = ubt_pkg::DATA_W,
   parameter int unsigned DEPTH = ubt_pkg::BUF_DEPTH
) (
   // clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             srst_i,
   // port A pin, split in three
   input  wire logic [WIDTH-1:0] port_a_data_i,
   output logic      [WIDTH-1:0] port_a_data_o,
   output logic                  port_a_data_oe_o,
   // port B pin, split in three
   input  wire logic [WIDTH-1:0] port_b_data_i,
   output logic      [WIDTH-1:0] port_b_data_o,
   output logic                  port_b_data_oe_o,
   // A-to-B controls
   input  wire logic             a_to_b_output_enable_i,
   input  wire logic             a_to_b_latch_control_i,
   input  wire logic             a_to_b_clock_i,
   // B-to-A controls
   input  wire logic             b_to_a_output_enable_n_i,
   input  wire logic             b_to_a_latch_control_i,
   input  wire logic             b_to_a_clock_i,
   // buffer handshake, A-to-B
   output logic                  a_to_b_in_ready_o,
   output logic                  a_to_b_out_valid_o,
   input  wire logic             a_to_b_out_ready_i,
   // buffer handshake, B-to-A
   output logic                  b_to_a_in_ready_o,
   output logic                  b_to_a_out_valid_o,
   input  wire logic             b_to_a_out_ready_i
);
   localparam int unsigned ND = ubt_pkg::NUM_DIR;
   localparam int unsigned AB = ubt_pkg::DIR_AB;
   localparam int unsigned BA = ubt_pkg::DIR_BA;

   // per-direction views, index AB for A-to-B and BA for B-to-A
   logic [ND-1:0][WIDTH-1:0] pin_in;
   logic [ND-1:0][WIDTH-1:0] src_q;
   logic [ND-1:0][WIDTH-1:0] out_q;
   logic [ND-1:0][WIDTH-1:0] head;
   logic [ND-1:0]            le;
   logic [ND-1:0]            le_q;
   logic [ND-1:0]            clk_pin;
   logic [ND-1:0]            clk_q;
   logic [ND-1:0]            en;
   logic [ND-1:0]            oe_q;
   logic [ND-1:0]            rise;
   logic [ND-1:0]            cap;
   logic [ND-1:0]            push;
   logic [ND-1:0]            pop;
   logic [ND-1:0]            in_rdy;
   logic [ND-1:0]            head_vld;
   logic [ND-1:0]            out_rdy;
   logic [ND-1:0]            rdy_q;
   logic [ND-1:0]            vld_q;

   // true when the capture element of a direction takes its source
   function automatic logic ubt_capture(input logic latch_ctl, input logic clk_rise);
      ubt_capture = latch_ctl | clk_rise;
   endfunction

   // gather the pins into direction order
   assign pin_in[AB]  = port_a_data_i;
   assign pin_in[BA]  = port_b_data_i;
   assign le[AB]      = a_to_b_latch_control_i;
   assign le[BA]      = b_to_a_latch_control_i;
   assign clk_pin[AB] = a_to_b_clock_i;
   assign clk_pin[BA] = b_to_a_clock_i;
   assign en[AB]      = a_to_b_output_enable_i;
   assign en[BA]      = ~b_to_a_output_enable_n_i;
   assign out_rdy[AB] = a_to_b_out_ready_i;
   assign out_rdy[BA] = b_to_a_out_ready_i;

   // the port this direction drives is the source of the other one
   genvar d;
   generate
      for (d = 0; d < ND; d++)
      begin : g_dir
         // clock pin edge seen against last sample
         assign rise[d] = clk_pin[d] & ~clk_q[d];
         // latch control high or clock edge takes the source
         assign cap[d]  = ubt_capture(le[d], rise[d]);
         // a full buffer stalls capture rather than overwrite
         assign push[d] = cap[d] & in_rdy[d];
         assign pop[d]  = head_vld[d] & out_rdy[d];

         // bus hold: keep the last outside level while this block drives
         // the line itself, so our own drive never feeds back
         always_ff @(posedge ref_clk_i)
         begin
            if (srst_i)
            begin
               src_q[d] <= ubt_pkg::DATA_RST;
            end
            else if (!oe_q[ND-1-d])
            begin
               src_q[d] <= pin_in[d];
            end
         end

         // edge and level history of the direction controls
         always_ff @(posedge ref_clk_i)
         begin
            if (srst_i)
            begin
               clk_q[d] <= ubt_pkg::PIN_RST;
               le_q[d]  <= ubt_pkg::PIN_RST;
            end
            else
            begin
               clk_q[d] <= clk_pin[d];
               le_q[d]  <= le[d];
            end
         end

         // two-entry buffer between capture and output register
         ubt_fifo #(
            .WIDTH (WIDTH),
            .DEPTH (DEPTH)
         ) u_buf (
            .ref_clk_i   (ref_clk_i),
            .srst_i      (srst_i),
            .in_valid_i  (cap[d]),
            .in_ready_o  (in_rdy[d]),
            .in_data_i   (src_q[d]),
            .out_valid_o (head_vld[d]),
            .out_ready_i (out_rdy[d]),
            .out_data_o  (head[d])
         );

         // output register holds the last word: hold and freeze modes
         always_ff @(posedge ref_clk_i)
         begin
            if (srst_i)
            begin
               out_q[d] <= ubt_pkg::DATA_RST;
            end
            else if (pop[d])
            begin
               out_q[d] <= head[d];
            end
         end

         // output enable, independent of latch, clock and data
         always_ff @(posedge ref_clk_i)
         begin
            if (srst_i)
            begin
               oe_q[d] <= ubt_pkg::OE_RST;
            end
            else
            begin
               oe_q[d] <= en[d];
            end
         end

         // handshake flags registered to keep outputs flop-driven
         always_ff @(posedge ref_clk_i)
         begin
            if (srst_i)
            begin
               rdy_q[d] <= 1'b0;
               vld_q[d] <= 1'b0;
            end
            else
            begin
               rdy_q[d] <= in_rdy[d];
               vld_q[d] <= head_vld[d];
            end
         end
      end
   endgenerate

   // pins out, no inversion on the data path; only the active-low B-to-A enable is inverted, where the pins are gathered
   assign port_b_data_o      = out_q[AB];
   assign port_a_data_o      = out_q[BA];
   assign port_b_data_oe_o   = oe_q[AB];
   assign port_a_data_oe_o   = oe_q[BA];
   assign a_to_b_in_ready_o  = rdy_q[AB];
   assign b_to_a_in_ready_o  = rdy_q[BA];
   assign a_to_b_out_valid_o = vld_q[AB];
   assign b_to_a_out_valid_o = vld_q[BA];

   // helper: buffer empty at push time, for the end-to-end latency check
   logic ab_empty;
   assign ab_empty = ~head_vld[AB];

   // all checks run on the reference clock and stay quiet while reset is held
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);

   property p_ab_oe_follow;
      1'b1 |=> port_b_data_oe_o == $past(a_to_b_output_enable_i);
   endproperty
   a_ab_oe_follow : assert property (p_ab_oe_follow)
      else $error("b drive enable does not follow its enable");

   property p_ab_oe_off;
      !a_to_b_output_enable_i ##1 !a_to_b_output_enable_i |-> !port_b_data_oe_o;
   endproperty
   a_ab_oe_off : assert property (p_ab_oe_off)
      else $error("b driven while its enable is low");

   property p_ba_oe_low;
      b_to_a_output_enable_n_i |=> !port_a_data_oe_o;
   endproperty
   a_ba_oe_low : assert property (p_ba_oe_low)
      else $error("a driven while its active-low enable is high");

   // data path checks, A-to-B, with the B-to-A no-clock capture check
   property p_transp_push;
      (a_to_b_latch_control_i && in_rdy[AB]) |=> head_vld[AB];
   endproperty
   a_transp_push : assert property (p_transp_push)
      else $error("transparent mode did not take the a data");

   property p_hold_steady;
      (!pop[AB]) |=> $stable(port_b_data_o);
   endproperty
   a_hold_steady : assert property (p_hold_steady)
      else $error("b data changed with nothing taken");

   property p_clk_path;
      (push[AB] && ab_empty) ##1 pop[AB] |=> port_b_data_o == $past(src_q[AB], 2);
   endproperty
   a_clk_path : assert property (p_clk_path)
      else $error("captured a word not shown unchanged on b");

   property p_freeze;
      (le_q[AB] && !a_to_b_latch_control_i && $past(in_rdy[AB]) && $past(pop[AB]) && pop[AB])
         |=> port_b_data_o == $past(src_q[AB], 2);
   endproperty
   a_freeze : assert property (p_freeze)
      else $error("b does not show the word taken before the latch control fell");

   property p_ba_clock;
      (!b_to_a_latch_control_i && !rise[BA] && !head_vld[BA]) |=> !head_vld[BA];
   endproperty
   a_ba_clock : assert property (p_ba_clock)
      else $error("b-to-a took data without a clock edge");

   property p_bus_hold;
      oe_q[AB] |=> $stable(src_q[BA]);
   endproperty
   a_bus_hold : assert property (p_bus_hold)
      else $error("b input level lost while b is driven");

   // mirrored checks for the B-to-A direction
   property p_ba_oe_follow;
      1'b1 |=> port_a_data_oe_o == !$past(b_to_a_output_enable_n_i);
   endproperty
   a_ba_oe_follow : assert property (p_ba_oe_follow)
      else $error("a drive enable does not follow its active-low enable");

   property p_ba_path;
      (push[BA] && !head_vld[BA]) ##1 pop[BA] |=> port_a_data_o == $past(src_q[BA], 2);
   endproperty
   a_ba_path : assert property (p_ba_path)
      else $error("captured b word not shown unchanged on a");

   property p_hold_a;
      oe_q[BA] |=> $stable(src_q[AB]);
   endproperty
   a_hold_a : assert property (p_hold_a)
      else $error("a input level lost while a is driven");

   // refusal, idle and copy checks on the A-to-B buffer
   property p_full_refuse;
      (cap[AB] && !in_rdy[AB] && !pop[AB]) |=> !a_to_b_in_ready_o && a_to_b_out_valid_o;
   endproperty
   a_full_refuse : assert property (p_full_refuse)
      else $error("full buffer shown as ready or empty");

   property p_ab_idle;
      (!a_to_b_latch_control_i && !rise[AB] && !head_vld[AB]) |=> !head_vld[AB];
   endproperty
   a_ab_idle : assert property (p_ab_idle)
      else $error("a-to-b buffer filled with no capture");

   property p_no_invert;
      pop[AB] |=> port_b_data_o == $past(head[AB]);
   endproperty
   a_no_invert : assert property (p_no_invert)
      else $error("b word differs from the buffered word");

   c_transparent : cover property (a_to_b_latch_control_i ##1 pop[AB]);
   c_clocked     : cover property (!a_to_b_latch_control_i && rise[AB] && push[AB]);
   c_full_stall  : cover property (cap[AB] && !in_rdy[AB]);
   c_ba_drive    : cover property (!b_to_a_output_enable_n_i ##1 pop[BA]);
   c_freeze      : cover property (le_q[AB] && !a_to_b_latch_control_i && pop[AB]);
endmodule

// *** dv/ubt_bus_model.sv ***
`timescale 1ns/1ps
// far-side logic on both buses, yields each bus while the block drives it
module ubt_bus_model #(
   parameter int unsigned W = ubt_pkg::DATA_W
) (
   // values the far side wants on each bus
   input  wire logic [W-1:0] drv_a_i,
   input  wire logic [W-1:0] drv_b_i,
   // block's split pins
   input  wire logic [W-1:0] dev_a_i,
   input  wire logic         dev_a_oe_i,
   input  wire logic [W-1:0] dev_b_i,
   input  wire logic         dev_b_oe_i,
   // resolved wire levels
   output logic      [W-1:0] pin_a_o,
   output logic      [W-1:0] pin_b_o
);
   // never drive against the block, so no contention is modelled
   assign pin_a_o = dev_a_oe_i ? dev_a_i : drv_a_i;
   assign pin_b_o = dev_b_oe_i ? dev_b_i : drv_b_i;
endmodule

// *** dv/ubt_transceiver_bench.sv ***
`timescale 1ns/1ps
module ubt_transceiver_bench;
   typedef struct packed {logic le; logic pulse; logic [17:0] val; logic [17:0] expv;} ubt_row_t;
   logic        ref_clk_i, srst_i, a_oe, a_le, a_clk, b_oe_n, b_le, b_clk, a_rdy, b_rdy;
   logic [17:0] drv_a, drv_b, pin_a, pin_b, a_o, b_o, last;
   logic        a_oe_o, b_oe_o, a_in_rdy, a_out_vld, b_in_rdy, b_out_vld;
   int          num_errors, comparisons;
   ubt_row_t    rows [7];
   logic [17:0] seen_q [$];

   ubt_transceiver u_ubt_transceiver (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .port_a_data_i(pin_a), .port_a_data_o(a_o), .port_a_data_oe_o(a_oe_o),
      .port_b_data_i(pin_b), .port_b_data_o(b_o), .port_b_data_oe_o(b_oe_o),
      .a_to_b_output_enable_i(a_oe), .a_to_b_latch_control_i(a_le), .a_to_b_clock_i(a_clk),
      .b_to_a_output_enable_n_i(b_oe_n), .b_to_a_latch_control_i(b_le), .b_to_a_clock_i(b_clk),
      .a_to_b_in_ready_o(a_in_rdy), .a_to_b_out_valid_o(a_out_vld), .a_to_b_out_ready_i(a_rdy),
      .b_to_a_in_ready_o(b_in_rdy), .b_to_a_out_valid_o(b_out_vld), .b_to_a_out_ready_i(b_rdy)
   );

   ubt_bus_model u_ubt_bus_model (
      .drv_a_i(drv_a), .drv_b_i(drv_b), .dev_a_i(a_o), .dev_a_oe_i(a_oe_o),
      .dev_b_i(b_o), .dev_b_oe_i(b_oe_o), .pin_a_o(pin_a), .pin_b_o(pin_b)
   );

   // free-running reference clock
   initial
   begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   task automatic check(input logic [17:0] seen, input logic [17:0] expv);
      comparisons++;
      if (seen !== expv)
      begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, expv);
      end
   endtask

   task automatic stop_test();
      if (num_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // one rising edge on the direction clock pin, then it stays low
   task automatic clk_pulse(input int d);
      if (d == 0) a_clk <= 1'b1; else b_clk <= 1'b1;
      cyc(1);
      if (d == 0) a_clk <= 1'b0; else b_clk <= 1'b0;
      cyc(2);
   endtask

   // latch control settles before data moves, so a freeze keeps the older word
   task automatic run_row(input int d, input ubt_row_t r);
      if (d == 0) a_le <= r.le; else b_le <= r.le;
      cyc(3);
      if (d == 0) drv_a <= r.val; else drv_b <= r.val;
      cyc(3);
      if (r.pulse) clk_pulse(d);
      cyc(6);
      check((d == 0) ? b_o : a_o, r.expv);
   endtask

   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #50us;
      num_errors++;
      stop_test();
   end

   initial
   begin
      rows[0] = '{1'b1, 1'b0, 18'h3ffff, 18'h3ffff};
      rows[1] = '{1'b1, 1'b0, 18'h00000, 18'h00000};
      rows[2] = '{1'b0, 1'b0, 18'h2aaaa, 18'h00000};
      rows[3] = '{1'b0, 1'b1, 18'h15555, 18'h15555};
      rows[4] = '{1'b0, 1'b0, 18'h00001, 18'h15555};
      rows[5] = '{1'b1, 1'b0, 18'h20001, 18'h20001};
      rows[6] = '{1'b0, 1'b0, 18'h0abcd, 18'h20001};
      {a_oe, a_le, a_clk, b_le, b_clk} = 5'h00;
      {b_oe_n, a_rdy, b_rdy, srst_i} = 4'hf;
      drv_a = 18'h00000;
      drv_b = 18'h00000;
      num_errors = 0;
      comparisons = 0;
      cyc(6);
      // everything quiet while reset is held
      check(b_o | a_o, 18'h00000);
      check(18'({a_oe_o, b_oe_o, a_in_rdy, b_in_rdy, a_out_vld, b_out_vld}), 18'h00000);
      srst_i <= 1'b0;
      cyc(3);
      check(18'({a_in_rdy, b_in_rdy}), 18'h00003);
      // ordinary cases, A-to-B then B-to-A with the other side released
      for (int d = 0; d < 2; d++)
      begin
         a_oe <= (d == 0);
         b_oe_n <= (d == 0);
         cyc(3);
         check(18'(b_oe_o), 18'(d == 0));
         check(18'(a_oe_o), 18'(d == 1));
         foreach (rows[i]) run_row(d, rows[i]);
      end
      // stalled receiver: two words kept, the third refused
      a_oe <= 1'b1;
      b_oe_n <= 1'b1;
      a_rdy <= 1'b0;
      cyc(4);
      foreach (rows[i])
         if (i < 3)
         begin
            drv_a <= 18'(18'h11111 * (i + 1));
            cyc(3);
            clk_pulse(0);
         end
      cyc(2);
      check(18'({a_in_rdy, a_out_vld}), 18'h00001);
      check(b_o, 18'h20001);
      last = b_o;
      a_rdy <= 1'b1;
      repeat (10)
      begin
         cyc(1);
         if (b_o !== last) seen_q.push_back(b_o);
         last = b_o;
      end
      check(18'(seen_q.size()), 18'h00002);
      check(seen_q[0], 18'h11111);
      check(seen_q[1], 18'h22222);
      // reset in mid-run clears both words and the flags, controls left as they are
      srst_i <= 1'b1;
      cyc(2);
      check(b_o | a_o, 18'h00000);
      check(18'({a_oe_o, b_oe_o, a_in_rdy, b_in_rdy, a_out_vld, b_out_vld}), 18'h00000);
      srst_i <= 1'b0;
      cyc(3);
      check(18'({b_oe_o, a_in_rdy, b_in_rdy, a_out_vld}), 18'h0000e);
      check(b_o, 18'h00000);
      stop_test();
   end
endmodule
